// >>> wdt_pkg.sv
package wdt_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int LPO_PERIOD_PS = 1000000000;
    localparam int LPO_DIV_CYC   = LPO_PERIOD_PS / CLK_PERIOD_PS;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_RST_ST = 8'h00;
    localparam logic [7:0] ADDR_OPT1   = 8'h04;
    localparam logic [7:0] ADDR_OPT2   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h10;
    localparam logic [7:0] ADDR_CNT_LO = 8'h14;
    localparam logic [7:0] ADDR_CNT_HI = 8'h18;

    // ==========================================================
    // field positions
    localparam int CAUSE_POS     = 5;
    localparam int OPT1_TSEL_POS = 6;
    localparam int OPT1_LOCK_POS = 0;
    localparam int OPT2_CLKS_POS = 7;
    localparam int OPT2_WIN_POS  = 6;
    localparam int OPT2_LOCK_POS = 0;
    localparam int IRQ_W         = 2;
    localparam int IRQ_SVC_POS   = 0;
    localparam int IRQ_WIN_POS   = 1;

    // ==========================================================
    // service values
    localparam logic [15:0] SVC_FIRST  = 16'h0055;
    localparam logic [15:0] SVC_SECOND = 16'h00AA;

    // ==========================================================
    // configuration
    localparam logic       CLK_LPO = 1'b0;
    localparam logic       CLK_BUS = 1'b1;
    localparam logic [1:0] TSEL_OFF = 2'h0;

    typedef struct packed {
        logic [1:0] timeout_sel;
        logic       clk_sel;
        logic       window_en;
    } wdt_cfg_s;

    localparam wdt_cfg_s CFG_RST = '{timeout_sel: 2'h3,
                                      clk_sel:     CLK_LPO,
                                      window_en:   1'b0};

    typedef enum logic {
        SVC_IDLE  = 1'b0,
        SVC_ARMED = 1'b1
    } wdt_svc_e;

    // ==========================================================
    // terminal counts and window starts
    localparam logic [17:0] TC_LPO_1 = 18'((1 << 5) - 1);
    localparam logic [17:0] TC_LPO_2 = 18'((1 << 8) - 1);
    localparam logic [17:0] TC_LPO_3 = 18'((1 << 10) - 1);
    localparam logic [17:0] TC_BUS_1 = 18'((1 << 13) - 1);
    localparam logic [17:0] TC_BUS_2 = 18'((1 << 16) - 1);
    localparam logic [17:0] TC_BUS_3 = 18'((1 << 18) - 1);
    localparam logic [17:0] WIN_BUS_1 = 18'h01800;
    localparam logic [17:0] WIN_BUS_2 = 18'h0C000;
    localparam logic [17:0] WIN_BUS_3 = 18'h30000;

endpackage

// >>> wdt_div.sv
`timescale 1ns/1ps
module wdt_div #(
    parameter int DIV = 4
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // tick
    output logic      tick_o
);

    // ==========================================================
    // free running divider
    logic [15:0] cnt_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b0;
        end else if (cnt_q == 16'(DIV - 1)) begin
            cnt_q  <= 16'h0000;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            tick_o <= 1'b0;
        end
    end

endmodule

// >>> wdt_flag.sv
`timescale 1ns/1ps
module wdt_flag (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic set_i,
    input  wire logic clr_i,
    // state
    output logic      flag_o
);

    // ==========================================================
    // sticky flag, set wins
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end

endmodule

// >>> wdt_top.sv
`timescale 1ns/1ps
// Functional notes
// RULE1: watchdog enabled after reset; timeout select 00 disables it entirely (code still sets the service irq flag on a service pair outside window mode)
// RULE2: writing 0x0055 then 0x00AA restarts the timeout period
// RULE3: service writes never change what the status register reads
// RULE4: no completed service before the timeout elapses gives system reset
// RULE5: any other value written to the status address resets at once
// RULE6: clock select picks bus or 1 kHz; two bits pick timeout
// RULE7: reset default is 1 kHz source with 2^10 cycle timeout
// RULE8: 1 kHz source gives 2^5, 2^8, 2^10 cycle timeouts
// RULE9: bus source gives 2^13, 2^16, 2^18 cycle timeouts
// RULE10: window mode accepts service only in the last quarter
// RULE11: service before the window opens resets at once
// RULE12: window mode works only with the bus clock source
// RULE13: first write to each option register sets and locks it
// RULE14: software should write both option registers early
// RULE15: software should not service from an interrupt routine
// RULE16: bus source counter holds in stop and debug, then resumes
// RULE17: 1 kHz source counter clears in stop and debug modes
// RULE18: status register flags a reset caused by the watchdog
// RULE19: second value alone, without first just before, does not restart
module wdt_top
    import wdt_pkg::*;
#(
    parameter int LPO_DIV = LPO_DIV_CYC
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [15:0]      rdata_o,
    // system modes
    input  wire logic        stop_mode_i,
    input  wire logic        bdm_mode_i,
    // outputs
    output logic             wdog_reset_o,
    output logic             irq_o
);

    // ==========================================================
    // declarations
    logic             rst_any;
    wdt_cfg_s         cfg_q;
    logic             opt1_lock_q;
    logic             opt2_lock_q;
    logic [17:0]      cnt_q;
    logic [17:0]      tc;
    logic [17:0]      win_lim;
    wdt_svc_e         svc_q;
    logic             reset_req_q;
    logic             cause_q;
    logic             rst_prev_q;
    logic [15:0]      rdata_q;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_mask_q;
    logic             lpo_tick;
    logic             tick;
    logic             hold;
    logic             enabled;
    logic             win_active;
    logic             win_open;
    logic             wr_rst_st;
    logic             svc_first;
    logic             svc_second;
    logic             bad_val;
    logic             early;
    logic             svc_ok;
    logic             timeout;
    logic             fail;

    assign rst_any = rst_i | por_i;

    // ==========================================================
    // low power clock enable
    wdt_div #(
        .DIV       (LPO_DIV)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_any),
        .tick_o    (lpo_tick)
    );

    // ==========================================================
    // count source and limits
    assign enabled = cfg_q.timeout_sel != TSEL_OFF; // see RULE1
    assign tick    = (cfg_q.clk_sel == CLK_BUS) ? 1'b1 : lpo_tick; // see RULE6
    assign hold    = stop_mode_i | bdm_mode_i;

    always_comb begin
        tc      = TC_LPO_3;
        win_lim = WIN_BUS_3;
        case ({cfg_q.clk_sel, cfg_q.timeout_sel})
            {CLK_LPO, 2'h1}: tc = TC_LPO_1; // see RULE8
            {CLK_LPO, 2'h2}: tc = TC_LPO_2; // see RULE8
            {CLK_LPO, 2'h3}: tc = TC_LPO_3; // see RULE8
            {CLK_BUS, 2'h1}: begin
                tc      = TC_BUS_1; // see RULE9
                win_lim = WIN_BUS_1; // see RULE10
            end
            {CLK_BUS, 2'h2}: begin
                tc      = TC_BUS_2; // see RULE9
                win_lim = WIN_BUS_2; // see RULE10
            end
            {CLK_BUS, 2'h3}: begin
                tc      = TC_BUS_3; // see RULE9
                win_lim = WIN_BUS_3; // see RULE10
            end
            default: begin
                tc      = TC_LPO_3;
                win_lim = WIN_BUS_3;
            end
        endcase
    end

    assign win_active = cfg_q.window_en && cfg_q.clk_sel == CLK_BUS; // see RULE12
    assign win_open   = cnt_q >= win_lim; // see RULE10

    // ==========================================================
    // service decode
    assign wr_rst_st  = wr_i && addr_i == ADDR_RST_ST;
    assign svc_first  = wr_rst_st && wdata_i == SVC_FIRST;
    assign svc_second = wr_rst_st && wdata_i == SVC_SECOND;
    assign bad_val    = wr_rst_st && !svc_first && !svc_second; // see RULE5
    assign early      = win_active && !win_open
                        && (svc_first || svc_second); // see RULE11
    assign svc_ok     = svc_second && svc_q == SVC_ARMED
                        && !early; // see RULE19
    assign timeout    = tick && !hold && cnt_q >= tc && !svc_ok; // see RULE4
    assign fail       = enabled && (bad_val || early || timeout);

    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            svc_q <= SVC_IDLE;
        end else if (wr_rst_st) begin
            case (svc_q)
                SVC_IDLE:  svc_q <= svc_first ? SVC_ARMED : SVC_IDLE;
                SVC_ARMED: svc_q <= svc_first ? SVC_ARMED : SVC_IDLE;
                default:   svc_q <= SVC_IDLE;
            endcase
        end
    end

    // ==========================================================
    // counter
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            cnt_q <= 18'h00000;
        end else if (svc_ok || !enabled) begin
            cnt_q <= 18'h00000; // see RULE2
        end else if (hold) begin
            if (cfg_q.clk_sel == CLK_LPO) begin
                cnt_q <= 18'h00000; // see RULE17
            end else begin
                cnt_q <= cnt_q; // see RULE16
            end
        end else if (tick) begin
            cnt_q <= (cnt_q >= tc) ? 18'h00000 : cnt_q + 18'h00001;
        end
    end

    // ==========================================================
    // reset request and cause
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            reset_req_q <= 1'b0;
        end else if (fail) begin
            reset_req_q <= 1'b1; // see RULE4
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (por_i) begin
            rst_prev_q <= 1'b0;
            cause_q    <= 1'b0;
        end else begin
            rst_prev_q <= rst_i;
            if (rst_i && !rst_prev_q) begin
                cause_q <= reset_req_q; // see RULE18
            end
        end
    end

    assign wdog_reset_o = reset_req_q;

    // ==========================================================
    // write once options
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            cfg_q       <= CFG_RST; // see RULE7
            opt1_lock_q <= 1'b0;
            opt2_lock_q <= 1'b0;
        end else begin
            if (wr_i && addr_i == ADDR_OPT1 && !opt1_lock_q) begin
                cfg_q.timeout_sel <= wdata_i[OPT1_TSEL_POS +: 2]; // see RULE13
                opt1_lock_q       <= 1'b1;
            end
            if (wr_i && addr_i == ADDR_OPT2 && !opt2_lock_q) begin
                cfg_q.clk_sel   <= wdata_i[OPT2_CLKS_POS]; // see RULE13
                cfg_q.window_en <= wdata_i[OPT2_WIN_POS];
                opt2_lock_q     <= 1'b1;
            end
        end
    end

    // ==========================================================
    // interrupts
    assign irq_set[IRQ_SVC_POS] = svc_ok;
    assign irq_set[IRQ_WIN_POS] = win_active && enabled && tick && !hold
                                  && cnt_q == win_lim - 18'h00001;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_flag
            assign irq_clr[gi] = wr_i && addr_i == ADDR_IRQ_ST
                                 && wdata_i[gi];
            wdt_flag u_flag (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_any),
                .set_i     (irq_set[gi]),
                .clr_i     (irq_clr[gi]),
                .flag_o    (irq_sts[gi])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            irq_mask_q <= '0;
        end else if (wr_i && addr_i == ADDR_IRQ_MK) begin
            irq_mask_q <= wdata_i[IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_sts & irq_mask_q);

    // ==========================================================
    // read port
    always_ff @(posedge ref_clk_i) begin
        if (rst_any) begin
            rdata_q <= 16'h0000;
        end else if (rd_i) begin
            rdata_q <= 16'h0000;
            case (addr_i)
                ADDR_RST_ST: rdata_q[CAUSE_POS] <= cause_q; // see RULE3
                ADDR_OPT1: begin
                    rdata_q[OPT1_TSEL_POS +: 2] <= cfg_q.timeout_sel;
                    rdata_q[OPT1_LOCK_POS]      <= opt1_lock_q;
                end
                ADDR_OPT2: begin
                    rdata_q[OPT2_CLKS_POS] <= cfg_q.clk_sel;
                    rdata_q[OPT2_WIN_POS]  <= cfg_q.window_en;
                    rdata_q[OPT2_LOCK_POS] <= opt2_lock_q;
                end
                ADDR_IRQ_ST: rdata_q[IRQ_W-1:0] <= irq_sts;
                ADDR_IRQ_MK: rdata_q[IRQ_W-1:0] <= irq_mask_q;
                ADDR_CNT_LO: rdata_q <= cnt_q[15:0];
                ADDR_CNT_HI: rdata_q[1:0] <= cnt_q[17:16];
                default:     rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign rdata_o = rdata_q;

    // ==========================================================
    // assertions
    sequence s_pair_done;
        svc_ok;
    endsequence

    sequence s_restarted;
        cnt_q == 18'h00000;
    endsequence

    a_default_cfg: assert property ( // see RULE1
        @(posedge ref_clk_i) disable iff (por_i)
        rst_i ##1 !rst_i |-> cfg_q == CFG_RST && enabled)
        else $error("config not at default after reset");

    a_disabled_quiet: assert property ( // see RULE1
        @(posedge ref_clk_i) disable iff (rst_any)
        !enabled && !reset_req_q |=> !reset_req_q)
        else $error("disabled watchdog raised reset");

    a_pair_restart: assert property ( // see RULE2
        @(posedge ref_clk_i) disable iff (rst_any)
        s_pair_done |=> s_restarted)
        else $error("service pair did not restart count");

    a_status_kept: assert property ( // see RULE3
        @(posedge ref_clk_i) disable iff (rst_any)
        wr_rst_st |=> $stable(cause_q))
        else $error("service write changed status");

    a_timeout_reset: assert property ( // see RULE4
        @(posedge ref_clk_i) disable iff (rst_any)
        enabled && tick && !hold && cnt_q == tc && !svc_ok
        |=> reset_req_q [*2])
        else $error("timeout gave no reset");

    a_bad_value: assert property ( // see RULE5
        @(posedge ref_clk_i) disable iff (rst_any)
        enabled && wr_rst_st && wdata_i != SVC_FIRST
        && wdata_i != SVC_SECOND |=> wdog_reset_o)
        else $error("illegal value did not reset");

    a_lpo_limit: assert property ( // see RULE8
        @(posedge ref_clk_i) disable iff (rst_any)
        cfg_q.clk_sel == CLK_LPO |-> cnt_q <= TC_LPO_3)
        else $error("1 kHz count beyond longest timeout");

    a_early_write: assert property ( // see RULE11
        @(posedge ref_clk_i) disable iff (rst_any)
        enabled && win_active && wr_rst_st && cnt_q < win_lim
        && (wdata_i == SVC_FIRST || wdata_i == SVC_SECOND)
        |=> wdog_reset_o)
        else $error("early service did not reset");

    a_no_lpo_window: assert property ( // see RULE12
        @(posedge ref_clk_i) disable iff (rst_any)
        cfg_q.clk_sel == CLK_LPO && enabled && svc_first
        && svc_q == SVC_IDLE && !reset_req_q && cnt_q < tc
        |=> !wdog_reset_o)
        else $error("window applied to 1 kHz source");

    a_opt_locked: assert property ( // see RULE13
        @(posedge ref_clk_i) disable iff (rst_any)
        opt1_lock_q && opt2_lock_q |=> $stable(cfg_q))
        else $error("locked options changed");

    a_bus_hold: assert property ( // see RULE16
        @(posedge ref_clk_i) disable iff (rst_any)
        enabled && cfg_q.clk_sel == CLK_BUS && hold && !svc_ok
        && $stable(cfg_q) |=> $stable(cnt_q))
        else $error("bus count moved while held");

    a_lpo_clear: assert property ( // see RULE17
        @(posedge ref_clk_i) disable iff (rst_any)
        cfg_q.clk_sel == CLK_LPO && hold && $stable(cfg_q)
        |=> s_restarted)
        else $error("1 kHz count not cleared in mode");

    a_cause_flag: assert property ( // see RULE18
        @(posedge ref_clk_i) disable iff (por_i)
        rst_i && !rst_prev_q && reset_req_q |=> cause_q [*3])
        else $error("watchdog reset cause not recorded");

    a_lone_second: assert property ( // see RULE19
        @(posedge ref_clk_i) disable iff (rst_any)
        svc_second && svc_q == SVC_IDLE && enabled && !hold
        && cnt_q != 18'h00000 && cnt_q < tc
        |=> cnt_q != 18'h00000)
        else $error("lone second value restarted count");

endmodule

// >>> wdt_rst_ctl.sv
`timescale 1ns/1ps
module wdt_rst_ctl (
    // clock
    input  wire logic ref_clk_i,
    // reset requests
    input  wire logic req_i,
    input  wire logic wdog_reset_i,
    // system reset
    output logic      rst_o
);

    // ==========================================================
    // system reset logic, stretches a watchdog request
    logic [1:0] hold_q;

    always_ff @(posedge ref_clk_i) begin
        if (wdog_reset_i) begin
            hold_q <= 2'h3;
        end else if (req_i) begin
            hold_q <= 2'h0;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
        rst_o <= req_i || wdog_reset_i || (hold_q != 2'h0);
    end

endmodule

// >>> tb_windowed_watchdog_timer.sv
`timescale 1ns/1ps
module tb_windowed_watchdog_timer
    import wdt_pkg::*;
;

    // ==========================================================
    // signals
    logic        ref_clk_i;
    logic        rst_i;
    logic        por_i;
    logic        rst_req;
    logic [7:0]  addr_i;
    logic [15:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [15:0] rdata_o;
    logic        stop_mode_i;
    logic        bdm_mode_i;
    logic        wdog_reset_o;
    logic        irq_o;
    int          err_total   = 0;
    int          comparisons = 0;
    int          rst_cnt     = 0;

`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

    // ==========================================================
    // design and system reset model
    wdt_top #(.LPO_DIV(4)) wdt_top_i (
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .por_i        (por_i),
        .addr_i       (addr_i),
        .wdata_i      (wdata_i),
        .wr_i         (wr_i),
        .rd_i         (rd_i),
        .rdata_o      (rdata_o),
        .stop_mode_i  (stop_mode_i),
        .bdm_mode_i   (bdm_mode_i),
        .wdog_reset_o (wdog_reset_o),
        .irq_o        (irq_o)
    );

    wdt_rst_ctl wdt_rst_ctl_i (
        .ref_clk_i    (ref_clk_i),
        .req_i        (rst_req),
        .wdog_reset_i (wdog_reset_o),
        .rst_o        (rst_i)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge wdog_reset_o) rst_cnt++;

    // ==========================================================
    // bus tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask

    task automatic svc();
        @(posedge ref_clk_i);
        addr_i  <= ADDR_RST_ST;
        wdata_i <= SVC_FIRST;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wdata_i <= SVC_SECOND;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask

    task automatic cfg(input logic [15:0] o1, input logic [15:0] o2);
        wr(ADDR_OPT1, o1);
        wr(ADDR_OPT2, o2);
    endtask

    task automatic settle();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (n < 20 && (rst_i !== 1'b0 || wdog_reset_o === 1'b1));
        `CHK(rst_i, 1'b0)
        if (rst_i !== 1'b0) begin
            wrap_up();
        end
    endtask

    task automatic expect_rst(input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (n < hi + 8 && wdog_reset_o !== 1'b1);
        `CHK(n >= lo && n <= hi, 1'b1)
        if (wdog_reset_o !== 1'b1) begin
            wrap_up();
        end else begin
            settle();
        end
    endtask

    task automatic quiet(input int n);
        int c0;
        c0 = rst_cnt;
        cyc(n);
        `CHK(rst_cnt - c0, 0)
    endtask

    task automatic done(input string name);
        $display("test %s done, %0d errors", name, err_total);
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        int c0;
        int t;
        addr_i      = 8'h00;
        wdata_i     = 16'h0000;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        stop_mode_i = 1'b0;
        bdm_mode_i  = 1'b0;
        por_i       = 1'b1;
        rst_req     = 1'b1;
        cyc(3);
        por_i   <= 1'b0;
        rst_req <= 1'b0;
        settle();
        rd(ADDR_OPT1, 16'h00C0);
        rd(ADDR_OPT2, 16'h0000);
        rd(ADDR_RST_ST, 16'h0000);
        rd(8'h40, 16'h0000);
        expect_rst(4070, 4100);
        rd(ADDR_RST_ST, 16'h0020);
        svc();
        rd(ADDR_RST_ST, 16'h0020);
        done("defaults");

        for (int s = 1; s <= 2; s++) begin
            t = 4 << ((s == 1) ? 5 : 8);
            cfg(16'(s << 6), 16'h0000);
            rd(ADDR_OPT1, 16'(s << 6) | 16'h0001);
            wr(ADDR_OPT1, 16'h0000);
            rd(ADDR_OPT1, 16'(s << 6) | 16'h0001);
            svc();
            expect_rst(t - 6, t + 6);
        end
        done("slow source");

        cfg(16'h0040, 16'h0000);
        wr(ADDR_IRQ_MK, 16'h0001);
        c0 = rst_cnt;
        repeat (3) begin
            cyc(90);
            svc(); // main loop service
        end
        `CHK(rst_cnt - c0, 0)
        rd(ADDR_IRQ_ST, 16'h0001);
        `CHK(irq_o, 1'b1)
        wr(ADDR_IRQ_ST, 16'h0001);
        rd(ADDR_IRQ_ST, 16'h0000);
        `CHK(irq_o, 1'b0)
        wr(ADDR_IRQ_MK, 16'h0000);
        svc();
        rd(ADDR_IRQ_ST, 16'h0001);
        `CHK(irq_o, 1'b0)
        cyc(60);
        wr(ADDR_RST_ST, SVC_SECOND);
        expect_rst(56, 72);
        done("service");

        cfg(16'h0040, 16'h0000);
        wr(ADDR_RST_ST, 16'h1234);
        expect_rst(1, 1);
        cfg(16'h0000, 16'h0000);
        c0 = rst_cnt;
        wr(ADDR_RST_ST, 16'h1234);
        cyc(4200);
        `CHK(rst_cnt - c0, 0)
        @(posedge ref_clk_i);
        rst_req <= 1'b1;
        @(posedge ref_clk_i);
        rst_req <= 1'b0;
        settle();
        done("illegal and off");

        cfg(16'h0040, 16'h0080);
        rd(ADDR_OPT2, 16'h0081);
        svc();
        expect_rst(8190, 8194);
        cfg(16'h0040, 16'h0080);
        svc();
        cyc(1000);
        stop_mode_i <= 1'b1;
        cyc(3000);
        stop_mode_i <= 1'b0;
        expect_rst(7188, 7196);
        cfg(16'h0040, 16'h0000);
        svc();
        cyc(60);
        bdm_mode_i <= 1'b1;
        cyc(50);
        bdm_mode_i <= 1'b0;
        expect_rst(120, 134);
        done("modes");

        cfg(16'h0040, 16'h00C0);
        wr(ADDR_RST_ST, SVC_FIRST);
        expect_rst(1, 1);
        cfg(16'h0040, 16'h00C0);
        rd(ADDR_OPT2, 16'h00C1);
        cyc(6200);
        svc();
        quiet(20);
        rd(ADDR_IRQ_ST, 16'h0003);
        wr(ADDR_RST_ST, SVC_FIRST);
        expect_rst(1, 1);
        cfg(16'h0040, 16'h0040);
        svc();
        quiet(20);
        expect_rst(100, 134);
        cfg(16'h0080, 16'h00C0);
        cyc(6200);
        rd(ADDR_CNT_HI, 16'h0000);
        wr(ADDR_RST_ST, SVC_FIRST);
        expect_rst(1, 1);
        done("window");
        wrap_up();
    end

endmodule
